//--- sovp_pkg.sv
// Purpose: Constants for the post-detect velocity parameter block
// Assumes: Velocity in thousandths of a user unit per second
// Notes:   Nonvolatile copy lives in sovp_nv_store
// Behaviour
// - Post-detect velocity range is 0.001 up to the velocity limit
// - A written velocity takes effect at once
// - Nonvolatile copy updated only by the persist-parameters command
// - Power-up loads the last saved copy, unsaved value lost
// - Never saved: power-up value is 1 unit per second
// - Offset mode ends a continuous move a distance after detection
// - On detection run at post-detect velocity, then decelerate to stop
// - Offset behaviour only while action select equals 2
// - Immediate write accepted only in mode 0; sequence writes in any mode
// - Action select 0 hard stop, 1 decel stop, 2 offset stop
package sovp_pkg;
  localparam int unsigned VEL_W = 32;
  localparam int unsigned DIST_W = 32;
  localparam logic [VEL_W-1:0] VEL_MIN = 32'h0000_0001;
  localparam logic [VEL_W-1:0] VEL_INIT = 32'h0000_03E8;
  localparam logic [1:0] ACT_HARD = 2'h0;
  localparam logic [1:0] ACT_DECEL = 2'h1;
  localparam logic [1:0] ACT_OFFSET = 2'h2;
  localparam logic [1:0] MODE_IMMEDIATE = 2'h0;
  localparam logic [1:0] ADDR_VEL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_SAVED = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_RUN    = 4'h2,
    ST_OFFSET = 4'h4,
    ST_STOP   = 4'h8
  } sovp_state_e;
endpackage : sovp_pkg

//--- sovp_nv_store.sv
// Purpose: Nonvolatile copy of the post-detect velocity
// Assumes: Contents survive core reset; valid flag marks a saved copy
// Notes:   Read data registered
`timescale 1ns/100ps
`default_nettype none
module sovp_nv_store
  import sovp_pkg::*;
#(
  parameter int unsigned WIDTH = VEL_W
) (
  input  wire logic             core_clk,
  input  wire logic             saveEn,
  input  wire logic [WIDTH-1:0] saveData,
  output logic      [WIDTH-1:0] loadData,
  output logic                  savedValid
);
  if (WIDTH < 2) begin : gBadWidth
    $error("WIDTH too small");
  end
  logic [WIDTH-1:0] cell_reg;
  logic [WIDTH-1:0] cell_next;
  logic             valid_reg = 1'b0;
  logic             valid_next;
  always_comb begin
    cell_next  = cell_reg;
    valid_next = valid_reg;
    if (saveEn) begin
      cell_next  = saveData;
      valid_next = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    cell_reg  <= cell_next;
    valid_reg <= valid_next;
    loadData  <= cell_next;
    savedValid <= valid_next;
  end
endmodule : sovp_nv_store
`default_nettype wire

//--- sovp_offset_ctrl.sv
// Purpose: Post-detect velocity parameter and offset stop sequencing
// Assumes: Inputs synchronous to core_clk; distance counted in step pulses
// Notes:   Register port: addr, wdata, wr, rd, rdata one cycle later
`timescale 1ns/100ps
`default_nettype none
module sovp_offset_ctrl
  import sovp_pkg::*;
#(
  parameter int unsigned VW = VEL_W,
  parameter int unsigned DW = DIST_W
) (
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  input  wire logic [1:0]    regAddr,
  input  wire logic [VW-1:0] regWdata,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [VW-1:0] regRdata,
  input  wire logic          seqSource,
  input  wire logic [1:0]    opMode,
  input  wire logic          persistParametersCmd,
  input  wire logic [VW-1:0] velocityLimit,
  input  wire logic [1:0]    detectActionSelect,
  input  wire logic          detectInputAssign,
  input  wire logic          detectEvent,
  input  wire logic [DW-1:0] postDetectDistance,
  input  wire logic          continuousMovePositive,
  input  wire logic          continuousMoveNegative,
  input  wire logic          stepPulse,
  output logic      [VW-1:0] postDetectVelocity,
  output logic               speedChange,
  output logic               decelStart,
  output logic               hardStop,
  output logic               offsetActive,
  output logic               writeRejected
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // Status read packs the one-hot state into the low bits
  if (VW < $bits(sovp_state_e)) begin : gBadVw
    $error("VW too small");
  end
  if (DW < 1) begin : gBadDw
    $error("DW too small");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic velInRange(input logic [VW-1:0] v, input logic [VW-1:0] lim);
    velInRange = (v >= VEL_MIN) && (v <= lim);
  endfunction : velInRange

  // ----------------------------------------------------------------
  // Nonvolatile store and power-up load
  // ----------------------------------------------------------------
  logic [VW-1:0] nvData;
  logic          nvValid;
  logic          loaded_reg;
  logic          loaded_next;
  // Save takes the value standing now, not one written this cycle
  // save on command
  sovp_nv_store #(.WIDTH(VW)) uNv (
    .core_clk   (core_clk),
    .saveEn     (persistParametersCmd),
    .saveData   (postDetectVelocity),
    .loadData   (nvData),
    .savedValid (nvValid)
  );

  // ----------------------------------------------------------------
  // Velocity parameter
  // ----------------------------------------------------------------
  logic [VW-1:0] vel_reg;
  logic [VW-1:0] vel_next;
  logic          rej_reg;
  logic          rej_next;
  logic          velWrite;
  assign velWrite = regWr && (regAddr == ADDR_VEL);
  always_comb begin
    vel_next    = vel_reg;
    rej_next    = 1'b0;
    loaded_next = 1'b1;
    // Load cycle wins; a write landing here is dropped
    if (!loaded_reg) begin
      vel_next = nvValid ? nvData : VEL_INIT;
    end else if (velWrite) begin
      if ((!seqSource && opMode != MODE_IMMEDIATE) ||
          !velInRange(regWdata, velocityLimit)) begin
        rej_next = 1'b1;
      end else begin
        vel_next = regWdata;
      end
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      vel_reg    <= VEL_INIT;
      rej_reg    <= 1'b0;
      loaded_reg <= 1'b0;
    end else begin
      vel_reg    <= vel_next;
      rej_reg    <= rej_next;
      loaded_reg <= loaded_next;
    end
  end
  assign postDetectVelocity = vel_reg;
  assign writeRejected      = rej_reg;

  // ----------------------------------------------------------------
  // Offset stop sequencer
  // ----------------------------------------------------------------
  sovp_state_e   st_reg;
  sovp_state_e   st_next;
  logic [DW-1:0] dist_reg;
  logic [DW-1:0] dist_next;
  logic          spd_next;
  logic          dec_next;
  logic          hard_next;
  logic          moving;
  logic          trig;
  assign moving = continuousMovePositive || continuousMoveNegative;
  assign trig = detectEvent && detectInputAssign;
  always_comb begin
    st_next   = st_reg;
    dist_next = dist_reg;
    spd_next  = 1'b0;
    dec_next  = 1'b0;
    hard_next = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        if (moving) st_next = ST_RUN;
      end
      ST_RUN: begin
        if (!moving) begin
          st_next = ST_IDLE;
        end else if (trig) begin
          unique case (detectActionSelect)
            ACT_HARD: begin
              hard_next = 1'b1;
              st_next   = ST_STOP;
            end
            ACT_DECEL: begin
              dec_next = 1'b1;
              st_next  = ST_STOP;
            end
            ACT_OFFSET: begin
              spd_next  = 1'b1;
              dist_next = postDetectDistance;
              st_next   = ST_OFFSET;
            end
            // Unused code: detection ignored, move runs on
            default: st_next = ST_RUN;
          endcase
        end
      end
      ST_OFFSET: begin
        // Zero distance stops at once, else one count per step
        // stop after distance
        if (!moving) begin
          st_next = ST_IDLE;
        end else if (dist_reg == '0) begin
          dec_next = 1'b1;
          st_next  = ST_STOP;
        end else if (stepPulse) begin
          dist_next = dist_reg - 1'b1;
        end
      end
      ST_STOP: begin
        if (!moving) st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg      <= ST_IDLE;
      dist_reg    <= '0;
      speedChange <= 1'b0;
      decelStart  <= 1'b0;
      hardStop    <= 1'b0;
    end else begin
      st_reg      <= st_next;
      dist_reg    <= dist_next;
      speedChange <= spd_next;
      decelStart  <= dec_next;
      hardStop    <= hard_next;
    end
  end
  assign offsetActive = (st_reg == ST_OFFSET);

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Idle cycles read zero so old data never lingers
  logic [VW-1:0] rd_next;
  always_comb begin
    rd_next = '0;
    if (regRd) begin
      unique case (regAddr)
        ADDR_VEL:    rd_next = vel_reg;
        ADDR_STATUS: rd_next = {{(VW-$bits(sovp_state_e)){1'b0}}, st_reg};
        ADDR_SAVED:  rd_next = nvValid ? nvData : VEL_INIT;
        default:     rd_next = '0;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) regRdata <= '0;
    else         regRdata <= rd_next;
  end
endmodule : sovp_offset_ctrl
`default_nettype wire

//--- sovp_step_model.sv
// Purpose: Step pulse source for the motion side
// Assumes: GAP cycles between steps while moving
// Notes:   Quiet when no move runs
`timescale 1ns/100ps
`default_nettype none
module sovp_step_model #(
  parameter int GAP = 2
) (
  input  wire logic core_clk,
  input  wire logic moving,
  output var  logic stepPulse
);
  int cnt = 0;
  always @(posedge core_clk) begin
    cnt <= (moving && cnt < GAP - 1) ? cnt + 1 : 0;
    stepPulse <= moving && cnt == GAP - 1;
  end
endmodule : sovp_step_model
`default_nettype wire

//--- sovp_chk_assertions.sv
// Purpose: Port checks of the post-detect velocity block
// Assumes: One clock domain
// Notes:   Attached by bind
`timescale 1ns/100ps
`default_nettype none
module sovp_chk
  import sovp_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire logic [1:0]       regAddr,
  input wire logic [VEL_W-1:0] regWdata,
  input wire logic             regWr,
  input wire logic             regRd,
  input wire logic [VEL_W-1:0] regRdata,
  input wire logic             seqSource,
  input wire logic [1:0]       opMode,
  input wire logic [VEL_W-1:0] velocityLimit,
  input wire logic [1:0]       detectActionSelect,
  input wire logic             detectInputAssign,
  input wire logic             detectEvent,
  input wire logic [VEL_W-1:0] postDetectVelocity,
  input wire logic             speedChange,
  input wire logic             hardStop,
  input wire logic             writeRejected
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic ok;
  assign ok = regWdata >= VEL_MIN && regWdata <= velocityLimit
              && (seqSource || opMode == MODE_IMMEDIATE);
  a_write_takes: assert property (
    regWr && regAddr == ADDR_VEL && ok |=> postDetectVelocity == $past(regWdata))
    else $error("write not applied");
  a_mode_refuse: assert property (
    regWr && regAddr == ADDR_VEL && !seqSource && opMode != MODE_IMMEDIATE |=>
    writeRejected && $stable(postDetectVelocity)) else $error("mode write taken");
  a_range_refuse: assert property (
    regWr && regAddr == ADDR_VEL && (regWdata < VEL_MIN || regWdata > velocityLimit)
    |=> writeRejected && $stable(postDetectVelocity)) else $error("range write taken");
  a_refuse_cause: assert property (
    writeRejected |-> $past(regWr)) else $error("stray reject");
  a_read_value: assert property (
    regRd && regAddr == ADDR_VEL |=> regRdata == $past(postDetectVelocity))
    else $error("bad read data");
  a_value_hold: assert property (
    !regWr && $past(arst_n) |=> $stable(postDetectVelocity)) else $error("value drift");
  a_change_cause: assert property (
    speedChange |-> $past(detectEvent) && $past(detectInputAssign)
    && $past(detectActionSelect) == ACT_OFFSET) else $error("stray speed change");
  a_hard_cause: assert property (
    hardStop |-> $past(detectEvent) && $past(detectActionSelect) == ACT_HARD)
    else $error("stray hard stop");
endmodule : sovp_chk
bind sovp_offset_ctrl sovp_chk u_chk (.*);
`default_nettype wire

//--- sovp_offset_ctrl_tb.sv
// Purpose: Self-checking bench of the post-detect velocity block
// Assumes: Limit 50000, distance 4 steps
// Notes:   Nonvolatile copy kept over a mid-run reset
`timescale 1ns/100ps
`default_nettype none
module sovp_offset_ctrl_tb;
  import sovp_pkg::*;
  logic core_clk = 0, arst_n = 0, regWr = 0, regRd = 0, seqSource = 0, stepPulse;
  logic persistParametersCmd = 0, detectInputAssign = 1, detectEvent = 0;
  logic continuousMovePositive = 0, continuousMoveNegative = 0;
  logic speedChange, decelStart, hardStop, offsetActive, writeRejected;
  logic [1:0] regAddr = 0, opMode = 0, detectActionSelect = 2;
  logic [31:0] regWdata = 0, regRdata, postDetectVelocity;
  logic [31:0] velocityLimit = 32'h0000_C350, postDetectDistance = 32'h4;
  logic [2:0] saw;
  logic [6:0] tab [6] = '{7'h53, 7'h5B, 7'h14, 7'h32, 7'h70, 7'h40};
  int miscompares = 0, num_checks = 0;
  sovp_offset_ctrl dut (.*);
  sovp_step_model u_step (.core_clk(core_clk), .stepPulse(stepPulse),
    .moving(continuousMovePositive | continuousMoveNegative));
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) saw |= {hardStop, decelStart, speedChange};
  task chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk) {regWr, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge core_clk) regWr <= 0;
  endtask : wr
  task rc(input logic [1:0] a, input logic [31:0] e);
    @(posedge core_clk) {regRd, regAddr} <= {1'b1, a};
    @(posedge core_clk) regRd <= 0;
    #1 chk(regRdata, e);
  endtask : rc
  task mv(input logic [6:0] t);
    #1 saw = 0;
    @(posedge core_clk) begin
      {detectActionSelect, detectInputAssign} <= t[6:4];
      {continuousMoveNegative, continuousMovePositive} <= {t[3], !t[3]};
    end
    repeat (3) @(posedge core_clk);
    detectEvent <= 1;
    @(posedge core_clk) detectEvent <= 0;
    #1 chk(32'(offsetActive), 32'(t[6:4] == 3'h5));
    repeat (20) @(posedge core_clk);
    {continuousMoveNegative, continuousMovePositive} <= 2'h0;
    repeat (3) @(posedge core_clk);
    #1 chk(32'(saw), 32'(t[2:0]));
    $display("test motion %h done", t);
  endtask : mv
  task results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    #20000 miscompares++;
    results;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1;
    repeat (2) @(posedge core_clk);
    rc(ADDR_VEL, VEL_INIT);
    rc(ADDR_SAVED, VEL_INIT);
    rc(ADDR_STATUS, 32'(ST_IDLE));
    wr(ADDR_VEL, 32'h0000_1388);
    #1 chk(postDetectVelocity, 32'h0000_1388);
    chk(32'(writeRejected), 32'h0);
    rc(ADDR_VEL, 32'h0000_1388);
    wr(ADDR_VEL, 32'h0);
    #1 chk(32'(writeRejected), 32'h1);
    wr(ADDR_VEL, 32'h0000_C351);
    #1 chk(32'(writeRejected), 32'h1);
    rc(ADDR_VEL, 32'h0000_1388);
    @(posedge core_clk) opMode <= 2'h1;
    wr(ADDR_VEL, 32'h0000_0064);
    #1 chk(32'(writeRejected), 32'h1);
    rc(ADDR_VEL, 32'h0000_1388);
    @(posedge core_clk) seqSource <= 1;
    wr(ADDR_VEL, 32'h0000_C350);
    rc(ADDR_VEL, 32'h0000_C350);
    @(posedge core_clk) {seqSource, opMode, persistParametersCmd} <= 4'h1;
    @(posedge core_clk) persistParametersCmd <= 0;
    wr(ADDR_VEL, 32'h0000_07D0);
    rc(ADDR_SAVED, 32'h0000_C350);
    @(posedge core_clk) arst_n <= 0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1;
    repeat (2) @(posedge core_clk);
    rc(ADDR_VEL, 32'h0000_C350);
    $display("test registers done");
    foreach (tab[i]) mv(tab[i]);
    results;
  end
endmodule : sovp_offset_ctrl_tb
`default_nettype wire
